//--- sine_channel.sv
// One phase accumulator with a quarter-wave sine lookup
`timescale 1ns/1ns
module sine_channel (
   input  wire logic                            hclk,
   input  wire logic                            hresetn,
   input  wire logic                            advance,
   input  wire logic [tone_pkg::FREQ_W-1:0]     inc,
   output logic signed [tone_pkg::SAMPLE_W-1:0] sample
);
   import tone_pkg::*;

   logic [PHASE_W-1:0] phase_q;
   logic [5:0]         top;
   logic [3:0]         idx;
   logic [6:0]         mag;

   function automatic logic [6:0] quarter(input logic [3:0] i);
      unique case (i)
         4'h0: quarter = 7'd6;
         4'h1: quarter = 7'd19;
         4'h2: quarter = 7'd31;
         4'h3: quarter = 7'd43;
         4'h4: quarter = 7'd54;
         4'h5: quarter = 7'd65;
         4'h6: quarter = 7'd76;
         4'h7: quarter = 7'd85;
         4'h8: quarter = 7'd94;
         4'h9: quarter = 7'd102;
         4'ha: quarter = 7'd109;
         4'hb: quarter = 7'd115;
         4'hc: quarter = 7'd120;
         4'hd: quarter = 7'd123;
         4'he: quarter = 7'd126;
         4'hf: quarter = 7'd127;
      endcase
   endfunction

   // 2^15 phase steps per turn at 32768 ticks per second give 1 Hz per LSB
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= 15'h0000;
      end else if (advance) begin
         phase_q <= phase_q + {3'b000, inc}; // R13 R1
      end
   end

   assign top = phase_q[PHASE_W-1 -: 6];
   assign idx = top[4] ? ~top[3:0] : top[3:0];
   assign mag = quarter(idx);
   assign sample = top[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   phase_step_a: assert property ( // R13
      advance |=> phase_q == $past(phase_q) + {3'b000, $past(inc)})
      else $error("phase did not step by the frequency value");

   phase_hold_a: assert property ( // R2
      !advance |=> $stable(phase_q))
      else $error("phase moved without a slow clock step");

endmodule

//--- tone_gen.sv
// Dual tone sine generator with AHB-Lite control and port-ten pin muxing
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

// How it works
// R1: Two sine channels are programmable from 1 to 4095 Hz in 1 Hz steps.
// R2: All tone and key tone timing comes from the 32768 Hz slow clock.
// R3: The control port is write-only and reads back as zero.
// R4: Write bits 7:6 pick row (00), column (01) or command (11).
// R5: Frequencies are 12 bits; a write loads bits 5:0 into one half.
// R6: Command bit 0 picks the high (1) or low (0) half for the next writes.
// R7: Command bit 5 powers the generator down without clearing registers.
// R8: Command bit 1 enables the tone output, and when 0 silences it.
// R9: Command bits 3:2 pick sum, row only, column only, or undefined.
// R10: Single channel switching between row and column keeps phase.
// R11: Command bit 4 makes a 1024 Hz square wave on the key tone output.
// R12: Port ten pins 0 and 1 carry tone and key tone by build option.
// R13: Each channel is a phase accumulator stepped by its frequency value; the row accumulator steps by the column value in column-only mode.
module tone_gen #(
   parameter logic tone_pin_option     = 1'b1,
   parameter logic key_tone_pin_option = 1'b1
) (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [31:0]                      hrdata,
   input  wire logic                        slow_clk,
   output logic [tone_pkg::SUM_W-1:0]       dual_tone_output,
   output logic                             dual_tone_valid,
   input  wire logic                        dual_tone_ready,
   input  wire logic [1:0]                  gpio_out,
   input  wire logic [1:0]                  gpio_oe,
   output logic [1:0]                       gpio_in,
   input  wire logic [1:0]                  port_ten_in,
   output logic [1:0]                       port_ten_out,
   output logic [1:0]                       port_ten_oe
);
   import tone_pkg::*;

   logic              take;
   logic              wr_pend_q;
   logic [31:0]       addr_q;
   logic [31:0]       rdata_q;
   logic              ctrl_wr;
   dest_t             dest;
   logic [5:0]        wdat;
   logic [FREQ_W-1:0] row_q;
   logic [FREQ_W-1:0] col_q;
   logic              half_select_q;
   logic              tone_en_q;
   chan_sel_t         chan_sel_q;
   logic              key_tone_enable_q;
   logic              power_down_switch_q;
   logic [2:0]        slow_sync_q;
   logic              slow_tick;
   logic              tick_pend_q;
   logic              advance;
   logic              buf_ready;
   logic [FREQ_W-1:0] row_inc;
   logic signed [SAMPLE_W-1:0] row_smp;
   logic signed [SAMPLE_W-1:0] col_smp;
   logic signed [SUM_W-1:0]    mix;
   logic [SUM_W-1:0]  push_data;
   logic [3:0]        key_cnt_q;
   logic              key_tone_q;
   logic              tone_bit_q;
   logic [1:0]        pin_meta_q;
   logic [1:0]        pin_sync_q;
   logic [31:0]       status;

   // Bus slave: zero wait states, always OKAY
   assign take      = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend_q <= take & hwrite;
         addr_q    <= haddr;
      end
   end

   assign status = {29'h0000_0000, dual_tone_valid, key_tone_q,
                    ~power_down_switch_q};

   // Only status reads back; the control port and unmapped words give zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (hready) begin
         rdata_q <= (take && !hwrite && haddr == STATUS_OFFSET) ?
                    status : 32'h0000_0000; // R3
      end
   end

   assign ctrl_wr = wr_pend_q && addr_q == CTRL_OFFSET;
   assign dest    = dest_t'(hwdata[DEST_POS +: 2]); // R4
   assign wdat    = hwdata[HALF_W-1:0];

   // Frequency halves; half_select_q decides which six bits a write lands in
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_q <= FREQ_RESET;
      end else if (ctrl_wr && dest == DEST_ROW) begin // R4
         if (half_select_q) begin
            row_q[FREQ_W-1:HALF_W] <= wdat; // R5 R6
         end else begin
            row_q[HALF_W-1:0] <= wdat; // R5 R6
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         col_q <= FREQ_RESET;
      end else if (ctrl_wr && dest == DEST_COL) begin // R4
         if (half_select_q) begin
            col_q[FREQ_W-1:HALF_W] <= wdat; // R5 R6
         end else begin
            col_q[HALF_W-1:0] <= wdat; // R5 R6
         end
      end
   end

   // Command register; power down leaves the frequency and command registers untouched but clears the key tone and tone pin flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_select_q       <= CMD_RESET[HALF_POS];
         tone_en_q           <= CMD_RESET[TONE_EN_POS];
         chan_sel_q          <= chan_sel_t'(CMD_RESET[CHSEL_POS +: 2]);
         key_tone_enable_q   <= CMD_RESET[KEY_EN_POS];
         power_down_switch_q <= CMD_RESET[PWR_DOWN_POS];
      end else if (ctrl_wr && dest == DEST_CMD) begin // R4
         half_select_q       <= hwdata[HALF_POS]; // R6
         tone_en_q           <= hwdata[TONE_EN_POS]; // R8
         chan_sel_q          <= chan_sel_t'(hwdata[CHSEL_POS +: 2]); // R9
         key_tone_enable_q   <= hwdata[KEY_EN_POS]; // R11
         power_down_switch_q <= hwdata[PWR_DOWN_POS]; // R7
      end
   end

   // Slow clock pin: two flops, then a third for the edge detect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_sync_q <= 3'b000;
      end else begin
         slow_sync_q <= {slow_sync_q[1:0], slow_clk};
      end
   end

   assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2]; // R2

   // A tick waits here while the buffer is full; a further tick during that wait merges into it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_pend_q <= 1'b0;
      end else begin
         tick_pend_q <= slow_tick | (tick_pend_q & ~advance);
      end
   end

   assign advance = tick_pend_q & buf_ready & ~power_down_switch_q; // R7 R2

   // Single row/column use runs on one accumulator, so a switch keeps phase
   assign row_inc = (chan_sel_q == SEL_COL) ? col_q : row_q; // R10

   sine_channel u_row (
      .hclk    (hclk),
      .hresetn (hresetn),
      .advance (advance),
      .inc     (row_inc),
      .sample  (row_smp)
   );

   sine_channel u_col (
      .hclk    (hclk),
      .hresetn (hresetn),
      .advance (advance),
      .inc     (col_q),
      .sample  (col_smp)
   );

   // Undefined selection gives silence
   always_comb begin
      unique case (chan_sel_q)
         SEL_SUM: mix = SUM_W'(row_smp) + SUM_W'(col_smp); // R9
         SEL_ROW: mix = SUM_W'(row_smp); // R9
         SEL_COL: mix = SUM_W'(row_smp); // R9 R10
         default: mix = '0;
      endcase
   end

   assign push_data = tone_en_q ? SUM_W'(mix) : '0; // R8

   two_entry_buffer #(
      .WIDTH (SUM_W)
   ) u_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (advance),
      .in_ready  (buf_ready),
      .in_data   (push_data),
      .out_valid (dual_tone_valid),
      .out_ready (dual_tone_ready),
      .out_data  (dual_tone_output)
   );

   // One-bit tone for the pin: high on the positive half of the waveform
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_bit_q <= 1'b0;
      end else if (!tone_en_q || power_down_switch_q) begin
         tone_bit_q <= 1'b0; // R8 R7
      end else if (advance) begin
         tone_bit_q <= ~mix[SUM_W-1] && mix != '0;
      end
   end

   // Key tone: toggle every 16 slow ticks for 1024 Hz
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_cnt_q  <= 4'h0;
         key_tone_q <= 1'b0;
      end else if (!key_tone_enable_q || power_down_switch_q) begin
         key_cnt_q  <= 4'h0; // R11 R7
         key_tone_q <= 1'b0;
      end else if (slow_tick) begin
         if (key_cnt_q == 4'(KEY_HALF_TICKS - 1)) begin
            key_cnt_q  <= 4'h0;
            key_tone_q <= ~key_tone_q; // R11 R2
         end else begin
            key_cnt_q <= key_cnt_q + 4'h1;
         end
      end
   end

   // Port ten muxing
   assign port_ten_out[0] = tone_pin_option ? tone_bit_q : gpio_out[0]; // R12
   assign port_ten_oe[0]  = tone_pin_option ? 1'b1 : gpio_oe[0]; // R12
   assign port_ten_out[1] = key_tone_pin_option ? key_tone_q : gpio_out[1];
   assign port_ten_oe[1]  = key_tone_pin_option ? 1'b1 : gpio_oe[1]; // R12
   assign gpio_in         = pin_sync_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_q <= 2'b00;
         pin_sync_q <= 2'b00;
      end else begin
         pin_meta_q <= port_ten_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence cmd_high_half;
      ctrl_wr && dest == DEST_CMD && hwdata[HALF_POS];
   endsequence

   sequence row_write_now;
      ctrl_wr && dest == DEST_ROW;
   endsequence

   port_reads_zero_a: assert property ( // R3
      take && !hwrite && haddr == CTRL_OFFSET ##1 1'b1
      |-> hrdata == 32'h0000_0000)
      else $error("control port read returned data");

   high_half_load_a: assert property ( // R6
      cmd_high_half ##1 !ctrl_wr ##1 row_write_now
      |=> row_q[FREQ_W-1:HALF_W] == $past(wdat)
          && $stable(row_q[HALF_W-1:0]))
      else $error("row high half not loaded after half select");

   col_low_load_a: assert property ( // R5
      ctrl_wr && dest == DEST_COL && !half_select_q
      |=> col_q[HALF_W-1:0] == $past(wdat) && $stable(col_q[FREQ_W-1:HALF_W]))
      else $error("column low half not loaded");

   rsv_dest_ignored_a: assert property ( // R4
      ctrl_wr && dest == DEST_RSV
      |=> $stable(row_q) && $stable(col_q) && $stable(chan_sel_q))
      else $error("reserved destination changed a register");

   power_down_keeps_a: assert property ( // R7
      power_down_switch_q && !ctrl_wr
      |=> $stable(row_q) && $stable(col_q) && !advance
          && !key_tone_q)
      else $error("power down disturbed state or kept running");

   tone_off_pin_a: assert property ( // R8
      !tone_en_q |-> push_data == '0 ##1 !tone_bit_q)
      else $error("tone output active while disabled");

   select_row_a: assert property ( // R9
      chan_sel_q == SEL_ROW && tone_en_q |-> push_data == SUM_W'(row_smp))
      else $error("row only selection output wrong sample");

   fsk_increment_a: assert property ( // R10
      chan_sel_q == SEL_COL |-> row_inc == col_q)
      else $error("single channel column step not from column value");

   key_toggle_rate_a: assert property ( // R11
      $changed(key_tone_q) && key_tone_enable_q && !power_down_switch_q
      |-> $past(slow_tick) && $past(key_cnt_q) == 4'(KEY_HALF_TICKS - 1))
      else $error("key tone toggled off its 16 tick period");

   tick_only_step_a: assert property ( // R2
      advance |-> tick_pend_q)
      else $error("channel advanced without a slow clock edge");

   pin_option_a: assert property ( // R12
      port_ten_out[1] == (key_tone_pin_option ? key_tone_q : gpio_out[1]))
      else $error("key tone pin mux wrong");

endmodule

//--- tone_gen_test.sv
// Self-checking bench for the dual tone sine generator
`timescale 1ns/1ns
module tone_gen_test;
   import tone_pkg::*;

   localparam int SKIP = 4;

   logic             hclk;
   logic             hresetn;
   logic             hsel;
   logic [31:0]      haddr;
   logic [1:0]       htrans;
   logic             hwrite;
   logic [2:0]       hsize;
   logic [31:0]      hwdata;
   wire logic        hready;
   logic             hreadyout;
   logic             hresp;
   logic [31:0]      hrdata;
   logic             slow_clk;
   logic [SUM_W-1:0] dual_tone_output;
   logic             dual_tone_valid;
   logic             dual_tone_ready;
   logic [1:0]       gpio_out;
   logic [1:0]       gpio_oe;
   logic [1:0]       gpio_in;
   logic [1:0]       ext_level;
   wire logic [1:0]  port_ten_in;
   logic [1:0]       port_ten_out;
   logic [1:0]       port_ten_oe;
   int               err_count;
   int               n_compared;
   logic [SUM_W-1:0] samples[$];
   logic [5:0]       cmd_bits;
   logic [31:0]      rd;
   logic [11:0]      row_f;
   logic [11:0]      col_f;
   int               cnt;
   logic             lvl;

   // One slave: its ready is the bus ready
   assign hready = hreadyout;
   // Pin level seen back: the driving party wins, else the outside level
   assign port_ten_in = (port_ten_oe & port_ten_out) | (~port_ten_oe & ext_level);

   tone_gen DUT (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .hsel             (hsel),
      .haddr            (haddr),
      .htrans           (htrans),
      .hwrite           (hwrite),
      .hsize            (hsize),
      .hwdata           (hwdata),
      .hready           (hready),
      .hreadyout        (hreadyout),
      .hresp            (hresp),
      .hrdata           (hrdata),
      .slow_clk         (slow_clk),
      .dual_tone_output (dual_tone_output),
      .dual_tone_valid  (dual_tone_valid),
      .dual_tone_ready  (dual_tone_ready),
      .gpio_out         (gpio_out),
      .gpio_oe          (gpio_oe),
      .gpio_in          (gpio_in),
      .port_ten_in      (port_ten_in),
      .port_ten_out     (port_ten_out),
      .port_ten_oe      (port_ten_oe)
   );

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Slow clock kept fast for run time, phase unrelated to hclk
   initial begin
      slow_clk = 1'b0;
      #7;
      forever #405 slow_clk = ~slow_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge hclk);
      err_count++;
      wrap_up();
   end

   task automatic wait_hready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         err_count++;
         wrap_up();
      end
   endtask

   task automatic bus(input logic [31:0] addr, input logic wr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
      haddr  <= addr;
      hwrite <= wr;
      htrans <= 2'b10;
      wait_hready();
      htrans <= 2'b00;
      hwdata <= wdata;
      wait_hready();
      rdata = hrdata;
   endtask

   // Upper bits are random on purpose: the port ignores them
   task automatic wr(input logic [7:0] data);
      logic [31:0] r;
      logic [31:0] junk;
      r = $urandom;
      bus(CTRL_OFFSET, 1'b1, {r[31:8], data}, junk);
   endtask

   function automatic logic [5:0] cmd_of(input logic pd, input logic key,
                                         input logic ten,
                                         input logic [1:0] sel);
      logic [5:0] c;
      c = 6'h00;
      c[PWR_DOWN_POS] = pd;
      c[KEY_EN_POS] = key;
      c[TONE_EN_POS] = ten;
      c[CHSEL_POS +: 2] = sel;
      return c;
   endfunction

   task automatic set_cmd(input logic [5:0] bits);
      cmd_bits = bits;
      wr({DEST_CMD, bits});
   endtask

   task automatic set_half(input dest_t d, input logic [5:0] v,
                           input logic high);
      logic [5:0] c;
      c = cmd_bits;
      c[HALF_POS] = high;
      wr({DEST_CMD, c});
      wr({d, v});
   endtask

   task automatic set_freq(input dest_t d, input logic [11:0] f);
      set_half(d, f[11:6], 1'b1);
      set_half(d, f[5:0], 1'b0);
   endtask

   function automatic logic [SUM_W-1:0] neg(input logic [SUM_W-1:0] x);
      return ~x + 1'b1;
   endfunction

   // Stall mode keeps ready low most of the time so the buffer fills up
   task automatic collect(input int n, input bit stall);
      int               guard;
      logic [SUM_W-1:0] held;
      logic             stalled;
      samples = {};
      guard = 0;
      stalled = 1'b0;
      while (samples.size() < n && guard < 20000) begin
         @(posedge hclk);
         guard++;
         if (stalled) begin
            check(dual_tone_output, held);
            check(dual_tone_valid, 1'b1);
         end
         stalled = dual_tone_valid === 1'b1 && dual_tone_ready === 1'b0;
         held = dual_tone_output;
         if (dual_tone_valid === 1'b1 && dual_tone_ready === 1'b1) begin
            samples.push_back(dual_tone_output);
            if (!stall) begin
               check(port_ten_out[0], $signed(dual_tone_output) > 0);
            end
         end
         dual_tone_ready <= stall ? ($urandom_range(0, 39) == 0) : 1'b1;
      end
      // Drain freely between runs: a stale word would skew the pin check
      @(posedge hclk);
      dual_tone_ready <= 1'b1;
      check(samples.size(), n);
   endtask

   // Half a period later the sine must come back negated
   task automatic check_half(input int h);
      int nz;
      nz = 0;
      for (int i = SKIP; i + h < samples.size(); i++) begin
         check(samples[i + h], neg(samples[i]));
         if (samples[i] !== '0) begin
            nz++;
         end
      end
      check(nz > 0, 1'b1);
   endtask

   task automatic check_zero;
      for (int i = SKIP; i < samples.size(); i++) begin
         check(samples[i], 0);
      end
   endtask

   task automatic key_gap(output int ticks);
      int   guard;
      logic l;
      logic sp;
      ticks = 0;
      guard = 0;
      l = port_ten_out[1];
      while (port_ten_out[1] === l && guard < 3000) begin
         @(posedge hclk);
         guard++;
      end
      l = port_ten_out[1];
      sp = slow_clk;
      while (port_ten_out[1] === l && guard < 3000) begin
         @(posedge hclk);
         guard++;
         if (slow_clk && !sp) begin
            ticks++;
         end
         sp = slow_clk;
      end
   endtask

   initial begin
      rd = $urandom(32'hc6928f74);
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      // Receiver starts ready, so no stale word sits in the buffer
      dual_tone_ready = 1'b1;
      gpio_out = 2'h0;
      gpio_oe = 2'h0;
      ext_level = 2'h0;
      err_count = 0;
      n_compared = 0;
      cmd_bits = 6'h00;
      repeat (9) @(posedge hclk);
      check(hreadyout, 1'b1);
      check(hresp, 1'b0);
      check(hrdata, 32'h0000_0000);
      check(dual_tone_valid, 1'b0);
      check(port_ten_out, 2'h0);
      check(port_ten_oe, 2'h3);
      @(posedge hclk);
      hresetn <= 1'b1;
      gpio_out <= 2'($urandom);
      gpio_oe <= 2'($urandom);
      ext_level <= 2'($urandom);
      @(posedge hclk);
      bus(STATUS_OFFSET, 1'b0, 32'h0000_0000, rd);
      check(rd & 32'hffff_fffb, 32'h0000_0001);
      bus(CTRL_OFFSET, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      bus(32'h0000_0010, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      row_f = $urandom_range(0, 1) ? 12'h800 : 12'h400;
      col_f = 12'hc00 - row_f;
      set_cmd(cmd_of(1'b0, 1'b0, 1'b1, SEL_ROW));
      set_freq(DEST_ROW, row_f);
      set_freq(DEST_COL, col_f);
      wr({DEST_RSV, 6'h3f});
      bus(CTRL_OFFSET, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      collect(40, 1'b0);
      check_half(16384 / row_f);
      set_cmd(cmd_of(1'b0, 1'b0, 1'b1, SEL_COL));
      collect(60, 1'b1);
      check_half(16384 / col_f);
      // Only the high half is rewritten; the low half stays zero
      set_half(DEST_COL, row_f[11:6], 1'b1);
      set_cmd(cmd_of(1'b0, 1'b0, 1'b1, SEL_SUM));
      collect(40, 1'b0);
      check_half(16384 / row_f);
      set_cmd(cmd_of(1'b0, 1'b0, 1'b1, SEL_UNDEF));
      collect(12, 1'b0);
      check_zero();
      set_cmd(cmd_of(1'b0, 1'b0, 1'b0, SEL_SUM));
      collect(12, 1'b0);
      check_zero();
      check(gpio_in, port_ten_in);
      set_cmd(cmd_of(1'b0, 1'b1, 1'b0, SEL_SUM));
      key_gap(cnt);
      check(cnt, KEY_HALF_TICKS);
      set_cmd(cmd_of(1'b0, 1'b0, 1'b0, SEL_SUM));
      lvl = port_ten_out[1];
      repeat (600) @(posedge hclk);
      check(port_ten_out[1], lvl);
      set_cmd(cmd_of(1'b1, 1'b0, 1'b1, SEL_ROW));
      repeat (60) @(posedge hclk);
      bus(STATUS_OFFSET, 1'b0, 32'h0000_0000, rd);
      check(rd[STAT_ON_POS], 1'b0);
      cnt = 0;
      repeat (200) begin
         @(posedge hclk);
         cnt += (dual_tone_valid !== 1'b0);
      end
      check(cnt, 0);
      set_cmd(cmd_of(1'b0, 1'b0, 1'b1, SEL_ROW));
      collect(40, 1'b0);
      check_half(16384 / row_f);
      wrap_up();
   end

endmodule

//--- tone_pkg.sv
// Shared constants and types for the dual tone sine generator
package tone_pkg;

   localparam int unsigned FREQ_W    = 12;
   localparam int unsigned HALF_W    = 6;
   localparam int unsigned PHASE_W   = 15;
   localparam int unsigned SAMPLE_W  = 8;
   localparam int unsigned SUM_W     = 9;
   localparam int unsigned CMD_W     = 6;

   // Register byte offsets on the bus
   localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

   // Field positions of a control port write
   localparam int unsigned DEST_POS     = 6;
   localparam int unsigned HALF_POS     = 0;
   localparam int unsigned TONE_EN_POS  = 1;
   localparam int unsigned CHSEL_POS    = 2;
   localparam int unsigned KEY_EN_POS   = 4;
   localparam int unsigned PWR_DOWN_POS = 5;

   // Status register bit positions
   localparam int unsigned STAT_ON_POS   = 0;
   localparam int unsigned STAT_KEY_POS  = 1;
   localparam int unsigned STAT_BUSY_POS = 2;

   // Reset values
   localparam logic [FREQ_W-1:0] FREQ_RESET = 12'h000;
   localparam logic [CMD_W-1:0]  CMD_RESET  = 6'h00;

   // Slow clock timing
   localparam int unsigned SLOW_CLK_HZ    = 32768;
   localparam int unsigned KEY_TONE_HZ    = 1024;
   localparam int unsigned KEY_HALF_TICKS = SLOW_CLK_HZ / (2 * KEY_TONE_HZ);

   typedef enum logic [1:0] {
      DEST_ROW = 2'b00,
      DEST_COL = 2'b01,
      DEST_RSV = 2'b10,
      DEST_CMD = 2'b11
   } dest_t;

   typedef enum logic [1:0] {
      SEL_SUM   = 2'b00,
      SEL_ROW   = 2'b01,
      SEL_COL   = 2'b10,
      SEL_UNDEF = 2'b11
   } chan_sel_t;

endpackage

//--- two_entry_buffer.sv
// Two-entry valid/ready buffer for output samples
`timescale 1ns/1ns
module two_entry_buffer #(
   parameter int unsigned WIDTH = 9
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [1:0]       count_q;
   logic             wr_ptr_q;
   logic             rd_ptr_q;
   logic             push;
   logic             pop;

   assign in_ready  = count_q != 2'd2;
   assign out_valid = count_q != 2'd0;
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q  <= 2'd0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
      end else begin
         count_q  <= count_q + {1'b0, push} - {1'b0, pop};
         wr_ptr_q <= wr_ptr_q ^ push;
         rd_ptr_q <= rd_ptr_q ^ pop;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   full_stall_a: assert property (
      count_q == 2'd2 && !out_ready |=> !in_ready && $stable(out_data))
      else $error("full buffer accepted or lost a word");

endmodule
